// >>> oaf_cfg.svh
`ifndef OAF_CFG_SVH
`define OAF_CFG_SVH

// ****************************************************************
// opcode field positions
// ****************************************************************
`define OAF_DST_MSB     5
`define OAF_DST_LSB     3
`define OAF_SRC_MSB     2
`define OAF_SRC_LSB     0
`define OAF_PAIR_MSB    5
`define OAF_PAIR_LSB    4
// ****************************************************************
// fixed codes and reset values
// ****************************************************************
`define OAF_REG_ACC     3'h7
`define OAF_REG_MEM     3'h6
`define OAF_RST_STEP    16'h0008
`define OAF_ADDR_RST    16'h0000
`define OAF_OP_LEN_REL  16'h0002
`endif

// >>> oaf_disp_add.sv
`timescale 1ns/1ps
`default_nettype none
`include "oaf_cfg.svh"
// ****************************************************************
// base plus signed displacement adder
// ****************************************************************
module oaf_disp_add #(
    parameter int AW = 16
) (
    // operands
    input  wire logic [AW-1:0] base,
    input  wire logic [7:0]    disp,
    // sum
    output logic [AW-1:0]      sum
);
    // sign extend the displacement byte then add, wrapping
    always_comb begin
        sum = base + {{(AW-8){disp[7]}}, disp};
    end
endmodule : oaf_disp_add
`default_nettype wire

// >>> oaf_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// fetch side model: presents one request per call
// ****************************************************************
module oaf_fetch_model (
    // request towards the former
    output var logic                REQ_VALID,
    output var oaf_pkg::oaf_mode_t  MODE,
    output var oaf_pkg::oaf_instr_t INSTR,
    output var logic                USE_SECOND_INDEX,
    output var oaf_pkg::oaf_regs_t  REGS
);
    import oaf_pkg::*;
    // idle bus at time zero
    initial begin
        REQ_VALID = 1'b0;
        MODE = OAF_M_REG;
        INSTR = '0;
        USE_SECOND_INDEX = 1'b0;
        REGS = '0;
    end
    // idle cycles flip the bytes so stale data never looks valid
    task automatic put(input logic v, input oaf_mode_t m, input oaf_instr_t i,
                       input logic s, input oaf_regs_t r);
        REQ_VALID = v;
        MODE = m;
        INSTR = v ? i : ~INSTR;
        USE_SECOND_INDEX = s;
        REGS = r;
    endtask : put
endmodule : oaf_fetch_model
`default_nettype wire

// >>> oaf_operand_former.sv
`timescale 1ns/1ps
`default_nettype none
`include "oaf_cfg.svh"
// ****************************************************************
// operand and address formation
// ****************************************************************
module oaf_operand_former (
    // clock and reset
    input  wire logic                REF_CLK,
    input  wire logic                RST,
    // request from fetch
    input  wire logic                REQ_VALID,
    input  wire oaf_pkg::oaf_mode_t  MODE,
    input  wire oaf_pkg::oaf_instr_t INSTR,
    input  wire logic                USE_SECOND_INDEX,
    input  wire oaf_pkg::oaf_regs_t  REGS,
    // formed result
    output logic                     RES_VALID,
    output oaf_pkg::oaf_result_t     RES
);
    import oaf_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    oaf_result_t res_r;       // registered result
    oaf_result_t res_nxt;     // next result
    logic        vld_r;       // result valid
    logic        vld_nxt;     // next valid
    logic [15:0] pc_next;     // address after instruction
    logic [15:0] idx_base;    // selected index register
    logic [15:0] idx_addr;    // index plus displacement
    logic [15:0] rel_addr;    // relative target
    logic [15:0] pair_val;    // named pair contents
    logic [15:0] word23;      // bytes two and three, low first
    logic [1:0]  pair_f;      // pair field

    assign pair_f = INSTR.opcode[`OAF_PAIR_MSB:`OAF_PAIR_LSB];
    assign word23 = {INSTR.byte3, INSTR.byte2};

    // relative base is the address after the two byte op
    assign pc_next = REGS.pc + `OAF_OP_LEN_REL;

    // pick index base
    assign idx_base = USE_SECOND_INDEX ? REGS.second_index_register
                                       : REGS.first_index_register;

    // indexed address adder
    oaf_disp_add #(.AW(16)) u_idx (
        .base (idx_base),
        .disp (INSTR.byte2),
        .sum  (idx_addr)
    );

    // relative target adder
    oaf_disp_add #(.AW(16)) u_rel (
        .base (pc_next),
        .disp (INSTR.byte2),
        .sum  (rel_addr)
    );

    // ************************************************************
    // register pair lookup
    // ************************************************************
    always_comb begin
        case (pair_f)
            2'h0:    pair_val = REGS.pair_bc;
            2'h1:    pair_val = REGS.pair_de;
            2'h2:    pair_val = REGS.memory_pointer_pair;
            default: pair_val = REGS.sp;
        endcase
    end

    // ************************************************************
    // next result
    // ************************************************************
    always_comb begin
        res_nxt          = '0;
        vld_nxt          = REQ_VALID;
        // register selects straight from opcode fields
        res_nxt.dst_sel  = INSTR.opcode[`OAF_DST_MSB:`OAF_DST_LSB];
        res_nxt.src_sel  = INSTR.opcode[`OAF_SRC_MSB:`OAF_SRC_LSB];
        res_nxt.pair_sel = pair_f;
        res_nxt.ret_addr = REGS.pc + 16'h0001;
        if (!REQ_VALID) begin
            // hold last result, drop valid
            res_nxt = res_r;
        end else begin
            case (MODE)
                OAF_M_REG: begin
                    // fields already set
                end
                OAF_M_IMPL: begin
                    // accumulator is implied destination
                    res_nxt.dst_sel = `OAF_REG_ACC;
                end
                OAF_M_IMM: begin
                    res_nxt.imm8 = INSTR.byte2;
                end
                OAF_M_IMMX: begin
                    res_nxt.imm16   = word23;
                    res_nxt.pair_wr = 1'b1;
                end
                OAF_M_DIR: begin
                    res_nxt.mem_en   = 1'b1;
                    res_nxt.mem_addr = word23;
                end
                OAF_M_JPDIR: begin
                    // direct_jump_op target
                    res_nxt.pc_load   = 1'b1;
                    res_nxt.pc_target = word23;
                end
                OAF_M_IND: begin
                    res_nxt.mem_en   = 1'b1;
                    res_nxt.mem_addr = pair_val;
                end
                OAF_M_IDX: begin
                    res_nxt.mem_en   = 1'b1;
                    res_nxt.mem_addr = idx_addr;
                end
                OAF_M_REL: begin
                    // relative_jump_op target
                    res_nxt.pc_load   = 1'b1;
                    res_nxt.pc_target = rel_addr;
                end
                OAF_M_RST: begin
                    // page zero vector, field times eight
                    res_nxt.pc_load   = 1'b1;
                    res_nxt.push_ret  = 1'b1;
                    res_nxt.pc_target = {10'h000, INSTR.opcode[5:3], 3'h0};
                end
                OAF_M_BIT: begin
                    // bit position from opcode, operand register or memory
                    res_nxt.bit_pos  = INSTR.opcode[5:3];
                    res_nxt.bit_mask = 8'h01 << INSTR.opcode[5:3];
                    if (INSTR.opcode[2:0] == `OAF_REG_MEM) begin
                        res_nxt.mem_en   = 1'b1;
                        res_nxt.mem_addr = REGS.memory_pointer_pair;
                    end
                end
                default: begin
                    res_nxt = '0;
                end
            endcase
        end
    end

    // ************************************************************
    // register the result
    // ************************************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            res_r <= '0;
            vld_r <= 1'b0;
        end else begin
            res_r <= res_nxt;
            vld_r <= vld_nxt;
        end
    end

    assign RES       = res_r;
    assign RES_VALID = vld_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    // register and implied selects
    a_impl_acc_dst: assert property (
        REQ_VALID && MODE == OAF_M_IMPL |=> RES.dst_sel == 3'h7)
        else $error("implied dst not acc");
    a_reg_fields: assert property (
        REQ_VALID && MODE == OAF_M_REG |=>
            RES.src_sel == $past(INSTR.opcode[2:0]) &&
            RES.dst_sel == $past(INSTR.opcode[5:3]))
        else $error("reg fields wrong");

    // immediate data
    a_imm_byte: assert property (
        REQ_VALID && MODE == OAF_M_IMM |=> RES.imm8 == $past(INSTR.byte2))
        else $error("imm8 wrong");
    a_immx_word: assert property (
        REQ_VALID && MODE == OAF_M_IMMX |=>
            RES.pair_wr && RES.imm16 == {$past(INSTR.byte3), $past(INSTR.byte2)} &&
            RES.pair_sel == $past(INSTR.opcode[5:4]))
        else $error("imm16 wrong");

    // direct address and direct jump
    a_dir_addr: assert property (
        REQ_VALID && MODE == OAF_M_DIR |=>
            RES.mem_en && RES.mem_addr == {$past(INSTR.byte3), $past(INSTR.byte2)})
        else $error("direct addr wrong");
    a_jp_target: assert property (
        REQ_VALID && MODE == OAF_M_JPDIR |=>
            RES.pc_load && RES.pc_target == {$past(INSTR.byte3), $past(INSTR.byte2)})
        else $error("jump target wrong");

    // pointer, index and relative forms
    a_ind_addr: assert property (
        REQ_VALID && MODE == OAF_M_IND && INSTR.opcode[5:4] == 2'h2 |=>
            RES.mem_en && RES.mem_addr == $past(REGS.memory_pointer_pair))
        else $error("indirect addr wrong");
    a_idx_addr: assert property (
        REQ_VALID && MODE == OAF_M_IDX && !USE_SECOND_INDEX |=>
            RES.mem_addr == 16'($past(REGS.first_index_register) +
                                {{8{$past(INSTR.byte2[7])}}, $past(INSTR.byte2)}))
        else $error("index addr wrong");
    a_idx_second: assert property (
        REQ_VALID && MODE == OAF_M_IDX && USE_SECOND_INDEX |=>
            RES.mem_addr == 16'($past(REGS.second_index_register) +
                                {{8{$past(INSTR.byte2[7])}}, $past(INSTR.byte2)}))
        else $error("second index addr wrong");
    a_rel_target: assert property (
        REQ_VALID && MODE == OAF_M_REL |=>
            RES.pc_load &&
            RES.pc_target == 16'($past(REGS.pc) + 16'h0002 +
                                 {{8{$past(INSTR.byte2[7])}}, $past(INSTR.byte2)}))
        else $error("relative target wrong");

    // restart vector and bit operations
    a_rst_vector: assert property (
        REQ_VALID && MODE == OAF_M_RST |=>
            RES.push_ret && RES.pc_load &&
            RES.pc_target == {10'h000, $past(INSTR.opcode[5:3]), 3'h0})
        else $error("restart vector wrong");
    a_bit_mask: assert property (
        REQ_VALID && MODE == OAF_M_BIT |=>
            $onehot(RES.bit_mask) && RES.bit_mask[RES.bit_pos] &&
            RES.bit_pos == $past(INSTR.opcode[5:3]))
        else $error("bit mask wrong");
    a_bit_mem: assert property (
        REQ_VALID && MODE == OAF_M_BIT && INSTR.opcode[2:0] == 3'h6 |=>
            RES.mem_en && RES.mem_addr == $past(REGS.memory_pointer_pair))
        else $error("bit memory operand wrong");

    // strobe follows request, result holds between requests
    a_valid_follow: assert property (
        REQ_VALID |=> RES_VALID)
        else $error("valid missing");
    a_idle_quiet: assert property (
        !REQ_VALID |=> !RES_VALID)
        else $error("valid without request");
    a_idle_hold: assert property (
        !REQ_VALID |=> $stable(RES))
        else $error("result moved while idle");

    // main scenarios worth seeing
    c_rel_back: cover property (REQ_VALID && MODE == OAF_M_REL && INSTR.byte2[7]);
    c_idx_second: cover property (REQ_VALID && MODE == OAF_M_IDX && USE_SECOND_INDEX);
    c_rst_top: cover property (REQ_VALID && MODE == OAF_M_RST && INSTR.opcode[5:3] == 3'h7);
    c_bit_mem: cover property (REQ_VALID && MODE == OAF_M_BIT && INSTR.opcode[2:0] == 3'h6);
endmodule : oaf_operand_former
`default_nettype wire

// >>> oaf_pkg.sv
// ****************************************************************
// shared types
// ****************************************************************
package oaf_pkg;
    // addressing mode requested by the instruction decoder
    typedef enum logic [3:0] {
        OAF_M_REG, OAF_M_IMPL, OAF_M_IMM, OAF_M_IMMX, OAF_M_DIR,
        OAF_M_JPDIR, OAF_M_IND, OAF_M_IDX, OAF_M_REL, OAF_M_RST, OAF_M_BIT
    } oaf_mode_t;
    // instruction bytes captured by fetch
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte2;
        logic [7:0] byte3;
    } oaf_instr_t;
    // current register state the decoder needs
    typedef struct packed {
        logic [15:0] pc;           // address of opcode
        logic [15:0] pair_bc;
        logic [15:0] pair_de;
        logic [15:0] memory_pointer_pair;
        logic [15:0] sp;
        logic [15:0] first_index_register;
        logic [15:0] second_index_register;
    } oaf_regs_t;
    // formed operands and addresses
    typedef struct packed {
        logic [2:0]  dst_sel;
        logic [2:0]  src_sel;
        logic [1:0]  pair_sel;
        logic        pair_wr;
        logic [7:0]  imm8;
        logic [15:0] imm16;
        logic        mem_en;
        logic [15:0] mem_addr;
        logic        pc_load;
        logic [15:0] pc_target;
        logic        push_ret;
        logic [15:0] ret_addr;
        logic [7:0]  bit_mask;
        logic [2:0]  bit_pos;
    } oaf_result_t;
endpackage : oaf_pkg

// >>> operand_address_formation_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module operand_address_formation_tb_top;
    import oaf_pkg::*;
    logic         ref_clk;    // 50 MHz clock
    logic         rst;        // sync reset
    logic         req_valid;  // request strobe
    oaf_mode_t    mode;       // addressing mode
    oaf_instr_t   instr;      // instruction bytes
    logic         use_second; // index select
    oaf_regs_t    regs;       // register state
    logic         res_valid;  // result strobe
    oaf_result_t  res;        // formed result
    int           mismatches;
    int           num_checks;
    logic         pv;         // previous cycle held a request
    oaf_mode_t    pm;
    oaf_instr_t   pi;
    oaf_regs_t    pr;
    logic         ps;
    oaf_operand_former dut (.REF_CLK(ref_clk), .RST(rst), .REQ_VALID(req_valid),
        .MODE(mode), .INSTR(instr), .USE_SECOND_INDEX(use_second), .REGS(regs),
        .RES_VALID(res_valid), .RES(res));
    oaf_fetch_model fetch (.REQ_VALID(req_valid), .MODE(mode), .INSTR(instr),
        .USE_SECOND_INDEX(use_second), .REGS(regs));
    // clock generator
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // compare one value
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // sign extend a displacement byte
    function automatic logic [15:0] sx(input logic [7:0] d);
        return {{8{d[7]}}, d};
    endfunction : sx
    // expected strobes {mem_en, pc_load, push_ret, pair_wr} of one request
    function automatic logic [3:0] flags(input oaf_mode_t m, input oaf_instr_t i);
        return {m == OAF_M_DIR || m == OAF_M_IND || m == OAF_M_IDX ||
                    (m == OAF_M_BIT && i.opcode[2:0] == 3'h6),
                m == OAF_M_JPDIR || m == OAF_M_REL || m == OAF_M_RST,
                m == OAF_M_RST,
                m == OAF_M_IMMX};
    endfunction : flags
    // expected result of one request, field by field
    task automatic check_res(input oaf_mode_t m, input oaf_instr_t i, input oaf_regs_t r,
                             input logic s);
        logic [15:0] w;
        logic [15:0] p;
        logic [15:0] d;
        logic [3:0]  f;
        w = {i.byte3, i.byte2};
        p = (i.opcode[5:4] == 2'h0) ? r.pair_bc : (i.opcode[5:4] == 2'h1) ? r.pair_de :
            (i.opcode[5:4] == 2'h2) ? r.memory_pointer_pair : r.sp;
        d = (m == OAF_M_IMPL) ? 16'h0007 : 16'(i.opcode[5:3]);
        f = {res.mem_en, res.pc_load, res.push_ret, res.pair_wr};
        chk("res_valid", 16'(res_valid), 16'h0001);
        if (m > OAF_M_BIT) begin
            // undecoded mode leaves every field clear
            chk("unknown_res", 16'(res != '0), 16'h0000);
            return;
        end
        chk("dst_sel", 16'(res.dst_sel), d);
        chk("src_sel", 16'(res.src_sel), 16'(i.opcode[2:0]));
        chk("pair_sel", 16'(res.pair_sel), 16'(i.opcode[5:4]));
        chk("flags", 16'(f), 16'(flags(m, i)));
        case (m)
            OAF_M_IMM: chk("imm8", 16'(res.imm8), 16'(i.byte2));
            OAF_M_IMMX: chk("imm16", res.imm16, w);
            OAF_M_DIR: chk("dir_addr", res.mem_addr, w);
            OAF_M_JPDIR: chk("jump_target", res.pc_target, w);
            OAF_M_IND: chk("ind_addr", res.mem_addr, p);
            OAF_M_IDX: chk("idx_addr", res.mem_addr, (s ? r.second_index_register :
                r.first_index_register) + sx(i.byte2));
            OAF_M_REL: chk("rel_target", res.pc_target,
                r.pc + 16'h0002 + sx(i.byte2));
            OAF_M_RST: begin
                chk("rst_target", res.pc_target, {10'h000, i.opcode[5:3], 3'h0});
                chk("ret_addr", res.ret_addr, r.pc + 16'h0001);
            end
            OAF_M_BIT: begin
                chk("bit_mask", 16'(res.bit_mask), 16'(8'h01 << i.opcode[5:3]));
                chk("bit_pos", 16'(res.bit_pos), 16'(i.opcode[5:3]));
                if (i.opcode[2:0] == 3'h6)
                    chk("bit_addr", res.mem_addr, r.memory_pointer_pair);
            end
            default: ;
        endcase
    endtask : check_res
    // one cycle: drive a request, then judge what the last one produced
    task automatic issue(input logic v, input oaf_mode_t m, input oaf_instr_t i,
                         input oaf_regs_t r, input logic s);
        @(posedge ref_clk);
        #1 fetch.put(v, m, i, s, r);
        #1 if (pv) check_res(pm, pi, pr, ps);
        else chk("idle_valid", 16'(res_valid), 16'h0000);
        {pv, pm, pi, pr, ps} = {v, m, i, r, s};
    endtask : issue
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial begin
        mismatches = 0;
        num_checks = 0;
        pv = 1'b0;
        rst = 1'b1;
        void'($urandom(32'hC475));
        repeat (3) @(posedge ref_clk);
        #1 rst = 1'b0;
        // corners: walk example, second index negative displacement, negative relative, last restart
        issue(1'b1, OAF_M_JPDIR, 24'hC37703, '0, 1'b0);
        issue(1'b1, OAF_M_IDX, 24'hDD8000, 112'(16'hFFF0) | (112'(16'h0010) << 16), 1'b1);
        issue(1'b1, OAF_M_REL, 24'h18FE00, {16'hFFFF, 96'h0}, 1'b0);
        issue(1'b1, OAF_M_RST, 24'hFF0000, {16'h1234, 96'h0}, 1'b0);
        issue(1'b1, OAF_M_IMPL, 24'h920000, '0, 1'b0);
        issue(1'b1, OAF_M_BIT, 24'hD60000, {48'h0, 16'h4321, 48'h0}, 1'b0);
        issue(1'b1, oaf_mode_t'(4'hF), 24'hFFFFFF, '1, 1'b1);
        issue(1'b0, OAF_M_REG, '0, '0, 1'b0);
        issue(1'b0, OAF_M_REG, '0, '0, 1'b0);
        $display("test corners done");
        // random traffic, mostly back to back
        repeat (400) issue($urandom_range(0, 3) != 0, oaf_mode_t'($urandom_range(0, 10)),
            24'($urandom), 112'({$urandom, $urandom, $urandom, $urandom}), 1'($urandom));
        $display("test random done");
        // reset in mid-run clears the result
        issue(1'b1, OAF_M_DIR, 24'h3A5566, '0, 1'b0);
        @(posedge ref_clk);
        #1 rst = 1'b1;
        fetch.put(1'b0, OAF_M_REG, '0, 1'b0, '0);
        check_res(pm, pi, pr, ps);
        @(posedge ref_clk);
        #1 chk("reset_valid", 16'(res_valid), 16'h0000);
        chk("reset_addr", res.mem_addr, 16'h0000);
        rst = 1'b0;
        pv = 1'b0;
        issue(1'b1, OAF_M_IND, 24'h6E0000, {48'h0, 16'hBEEF, 48'h0}, 1'b0);
        issue(1'b0, OAF_M_REG, '0, '0, 1'b0);
        $display("test reset done");
        test_done();
    end
endmodule : operand_address_formation_tb_top
`default_nettype wire
